/* File: dil_immediate_dma.sv */
// immediate-write dma channel with descriptor list walking
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
`include "dil_params.svh"
module dil_immediate_dma (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   output dil_pkg::dil_tlp_type REQ,
   output logic REQ_VALID,
   input wire logic REQ_READY,
   input wire logic CPL_VALID,
   input wire logic [31:0] CPL_DATA
);
   import dil_pkg::*;

   dil_state_type state_q;
   logic run_q;
   logic [4:0] sts_q;
   logic [3:0] cfg_q;
   logic [31:0] dpl_q;
   logic [31:0] dph_q;
   logic [31:0] ndl_q;
   logic [31:0] ndh_q;
   logic [31:0] desc_q [0:7];
   logic [2:0] cpl_idx_q;
   logic bad_q;
   logic [63:0] dst_q;
   logic [63:0] pay_q;
   logic [3:0] rem_q;

   // ----------------------------------------
   // software writes and start conditions
   // ----------------------------------------
   logic wr_ctrl, wr_sts, wr_cfg, wr_dpl, wr_dph, wr_ndl, wr_ndh;
   logic nz, idle_ok, st_run, st_dl, st_dh, st_chl, st_chh, sw_chain, start;
   logic [63:0] nd_wr;
   assign wr_ctrl = WR && ADDR == `DIL_OFS_CTRL;
   assign wr_sts = WR && ADDR == `DIL_OFS_STS;
   assign wr_cfg = WR && ADDR == `DIL_OFS_CFG;
   assign wr_dpl = WR && ADDR == `DIL_OFS_DPL;
   assign wr_dph = WR && ADDR == `DIL_OFS_DPH;
   assign wr_ndl = WR && ADDR == `DIL_OFS_NDL;
   assign wr_ndh = WR && ADDR == `DIL_OFS_NDH;
   assign nz = WDATA != 32'h0;
   assign idle_ok = !run_q && !sts_q[`DIL_STS_ERR] && state_q == S_IDLE;
   assign st_run = wr_ctrl && WDATA[`DIL_CTRL_RUN] && idle_ok;
   assign st_dl = wr_dpl && nz && !cfg_q[`DIL_CFG_NOST_L] && idle_ok;
   assign st_dh = wr_dph && nz && !cfg_q[`DIL_CFG_NOST_H] && idle_ok;
   assign st_chl = wr_ndl && nz && !cfg_q[`DIL_CFG_NOCH_L] && idle_ok;
   assign st_chh = wr_ndh && nz && !cfg_q[`DIL_CFG_NOCH_H] && idle_ok;
   assign sw_chain = st_chl || st_chh;
   assign start = st_run || st_dl || st_dh || sw_chain;
   assign nd_wr = {wr_ndh ? WDATA : ndh_q, wr_ndl ? WDATA : ndl_q};

   // ----------------------------------------
   // descriptor decode
   // ----------------------------------------
   logic [3:0] len_f;
   logic len_ok, kind_ok, final_f, notify_f;
   logic [63:0] next_f;
   logic last, chain_ok;
   assign len_f = desc_q[1][3:0];
   assign len_ok = len_f != 4'h0 && len_f <= `DIL_LEN_MAX;
   assign kind_ok = desc_q[0][`DIL_D_KIND_LO +: 3] == `DIL_KIND_IMM;
   assign final_f = desc_q[0][`DIL_D_FINAL];
   assign notify_f = desc_q[0][`DIL_D_NOTIFY];
   // next address from words 6 and 7
   assign next_f = {desc_q[7], desc_q[6]};
   assign last = final_f || next_f == 64'h0;
   assign chain_ok = (ndh_q != 32'h0 && !cfg_q[`DIL_CFG_NOCH_H]) ||
                     (ndl_q != 32'h0 && !cfg_q[`DIL_CFG_NOCH_L]);

   // ----------------------------------------
   // write chunk shaping
   // ----------------------------------------
   logic [12:0] room;
   logic [3:0] n;
   logic [1:0] lane;
   logic [15:0] ones;
   logic [15:0] mask;
   logic [3:0] len_dw;
   logic [3:0] last_be;
   assign room = `DIL_PAGE - {1'b0, dst_q[11:0]};
   // clip at the 4 KB page end
   assign n = (room < {9'h0, rem_q}) ? room[3:0] : rem_q;
   assign lane = dst_q[1:0];
   assign ones = (16'h0001 << n) - 16'h0001;
   assign mask = ones << lane;
   assign len_dw = 4'((5'(lane) + 5'(n) + 5'h03) >> 2);
   always_comb begin
      case (len_dw)
         4'h2: last_be = mask[7:4];
         4'h3: last_be = mask[11:8];
         default: last_be = 4'h0;
      endcase
   end

   // ----------------------------------------
   // sequencer events
   // ----------------------------------------
   logic iss_rd, iss_wr, iss_wb;
   logic ev_fin, ev_adv, ev_chain, ev_halt, ev_err;
   assign iss_rd = state_q == S_FETCH && !REQ_VALID;
   assign iss_wr = state_q == S_WRITE && !REQ_VALID && rem_q != 4'h0;
   assign iss_wb = state_q == S_WBACK && !REQ_VALID;
   assign ev_fin = iss_wb && !bad_q && notify_f;
   assign ev_adv = state_q == S_NEXT && !bad_q && !last;
   assign ev_chain = state_q == S_NEXT && !bad_q && last && chain_ok;
   assign ev_err = state_q == S_NEXT && bad_q;
   assign ev_halt = state_q == S_NEXT && !ev_adv && !ev_chain;

   // ----------------------------------------
   // channel sequencer
   // ----------------------------------------
   always_ff @(posedge CLK) begin
      if (RESET) begin
         state_q <= S_IDLE;
      end else begin
         case (state_q)
            S_IDLE: begin
               if (start) begin
                  state_q <= S_FETCH;
               end
            end
            S_FETCH: begin
               if (iss_rd) begin
                  state_q <= S_LOAD;
               end
            end
            S_LOAD: begin
               if (CPL_VALID && cpl_idx_q == 3'h7) begin
                  state_q <= S_CHECK;
               end
            end
            S_CHECK: begin
               state_q <= (kind_ok && len_ok) ? S_WRITE : S_WBACK;
            end
            S_WRITE: begin
               if (!REQ_VALID && rem_q == 4'h0) begin
                  state_q <= S_WBACK;
               end
            end
            S_WBACK: begin
               if (iss_wb) begin
                  state_q <= S_NEXT;
               end
            end
            S_NEXT: begin
               state_q <= (ev_adv || ev_chain) ? S_FETCH : S_IDLE;
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // completion capture
   // ----------------------------------------
   always_ff @(posedge CLK) begin
      if (RESET) begin
         cpl_idx_q <= 3'h0;
      end else if (state_q != S_LOAD) begin
         cpl_idx_q <= 3'h0;
      end else if (CPL_VALID) begin
         cpl_idx_q <= cpl_idx_q + 3'h1;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_desc
         always_ff @(posedge CLK) begin
            if (RESET) begin
               desc_q[gi] <= 32'h0;
            end else if (state_q == S_LOAD && CPL_VALID && cpl_idx_q == 3'(gi)) begin
               desc_q[gi] <= CPL_DATA;
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // payload and destination walk
   // ----------------------------------------
   always_ff @(posedge CLK) begin
      if (RESET) begin
         bad_q <= 1'b0;
         dst_q <= 64'h0;
         pay_q <= 64'h0;
         rem_q <= 4'h0;
      end else if (state_q == S_CHECK) begin
         bad_q <= !(kind_ok && len_ok);
         // destination from words 4 and 5
         dst_q <= {desc_q[5], desc_q[4]};
         // low word carries bytes one to four
         pay_q[31:0] <= desc_q[2];
         // high word only for five or more
         pay_q[63:32] <= (len_f >= `DIL_LEN_HI) ? desc_q[3] : 32'h0;
         rem_q <= (kind_ok && len_ok) ? len_f : 4'h0;
      end else if (iss_wr) begin
         dst_q <= dst_q + 64'(n);
         pay_q <= pay_q >> {n, 3'b000};
         rem_q <= rem_q - n;
      end
   end

   // ----------------------------------------
   // request output toward the express port
   // ----------------------------------------
   always_ff @(posedge CLK) begin
      if (RESET) begin
         REQ <= '0;
         REQ_VALID <= 1'b0;
      end else if (iss_rd) begin
         REQ <= '0;
         REQ.addr <= {dph_q, dpl_q[31:2]};
         REQ.addr64 <= dph_q != 32'h0;
         REQ.len_dw <= `DIL_DESC_DW;
         REQ.first_be <= 4'hF;
         REQ.last_be <= 4'hF;
         REQ_VALID <= 1'b1;
      end else if (iss_wr) begin
         REQ.is_write <= 1'b1;
         REQ.addr <= dst_q[63:2];
         REQ.addr64 <= dst_q[63:32] != 32'h0;
         REQ.len_dw <= len_dw;
         REQ.first_be <= mask[3:0];
         REQ.last_be <= last_be;
         REQ.tc <= desc_q[0][`DIL_D_TC_LO +: 3];
         REQ.ro <= desc_q[0][`DIL_D_RO];
         REQ.ns <= desc_q[0][`DIL_D_NS];
         REQ.data <= 96'({32'h0, pay_q} << {lane, 3'b000});
         REQ_VALID <= 1'b1;
      end else if (iss_wb) begin
         REQ.is_write <= 1'b1;
         REQ.addr <= {dph_q, dpl_q[31:2]};
         REQ.addr64 <= dph_q != 32'h0;
         REQ.len_dw <= 4'h1;
         REQ.first_be <= `DIL_BE_STATUS;
         REQ.last_be <= 4'h0;
         REQ.tc <= 3'h0;
         REQ.ro <= 1'b0;
         REQ.ns <= 1'b0;
         REQ.data <= {64'h0, desc_q[0][31:29], bad_q ? `DIL_ST_ERR : `DIL_ST_DONE,
                      desc_q[0][26:0]};
         REQ_VALID <= 1'b1;
      end else if (REQ_READY) begin
         REQ_VALID <= 1'b0;
      end
   end

   // ----------------------------------------
   // run bit and configuration
   // ----------------------------------------
   always_ff @(posedge CLK) begin
      if (RESET) begin
         run_q <= 1'b0;
         cfg_q <= `DIL_CFG_RESET;
      end else begin
         if (wr_cfg) begin
            cfg_q <= WDATA[3:0];
         end
         if (start) begin
            run_q <= 1'b1;
         end else if (ev_halt) begin
            run_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // status flags, set wins over clear
   // ----------------------------------------
   logic [3:0] sts_set;
   assign sts_set = {ev_err, ev_chain || sw_chain, ev_fin, ev_halt};
   always_ff @(posedge CLK) begin
      if (RESET) begin
         sts_q <= 5'h00;
      end else begin
         sts_q[3:0] <= (sts_q[3:0] & ~(wr_sts ? WDATA[3:0] : 4'h0)) | sts_set;
         sts_q[`DIL_STS_BUSY] <= state_q != S_IDLE;
      end
   end

   // ----------------------------------------
   // descriptor and next-list pointers
   // ----------------------------------------
   always_ff @(posedge CLK) begin
      if (RESET) begin
         dpl_q <= 32'h0;
         dph_q <= 32'h0;
         ndl_q <= 32'h0;
         ndh_q <= 32'h0;
      end else if (sw_chain || ev_chain) begin
         // chain loads pointer and clears next-list
         {dph_q, dpl_q} <= sw_chain ? nd_wr : {ndh_q, ndl_q};
         ndl_q <= 32'h0;
         ndh_q <= 32'h0;
      end else if (ev_adv) begin
         {dph_q, dpl_q} <= next_f;
      end else begin
         if (wr_dpl) begin
            dpl_q <= WDATA;
         end
         if (wr_dph) begin
            dph_q <= WDATA;
         end
         if (wr_ndl) begin
            ndl_q <= WDATA;
         end
         if (wr_ndh) begin
            ndh_q <= WDATA;
         end
      end
   end

   // ----------------------------------------
   // register read port
   // ----------------------------------------
   always_ff @(posedge CLK) begin
      if (RESET) begin
         RDATA <= 32'h0;
      end else if (RD) begin
         case (ADDR)
            `DIL_OFS_CTRL: RDATA <= {31'h0, run_q};
            `DIL_OFS_STS: RDATA <= {27'h0, sts_q};
            `DIL_OFS_CFG: RDATA <= {28'h0, cfg_q};
            `DIL_OFS_DPL: RDATA <= dpl_q;
            `DIL_OFS_DPH: RDATA <= dph_q;
            `DIL_OFS_NDL: RDATA <= ndl_q;
            `DIL_OFS_NDH: RDATA <= ndh_q;
            default: RDATA <= 32'h0;
         endcase
      end else begin
         RDATA <= 32'h0;
      end
   end
endmodule

/* File: dil_params.svh */
// offsets, field positions, encodings and reset values of the immediate dma channel
`ifndef DIL_PARAMS_SVH
`define DIL_PARAMS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define DIL_OFS_CTRL 8'h00
`define DIL_OFS_STS 8'h04
`define DIL_OFS_CFG 8'h08
`define DIL_OFS_DPL 8'h0C
`define DIL_OFS_DPH 8'h10
`define DIL_OFS_NDL 8'h14
`define DIL_OFS_NDH 8'h18
// ----------------------------------------
// register bit positions
// ----------------------------------------
`define DIL_CTRL_RUN 0
`define DIL_STS_HALT 0
`define DIL_STS_FIN 1
`define DIL_STS_CHAIN 2
`define DIL_STS_ERR 3
`define DIL_STS_BUSY 4
`define DIL_CFG_NOST_L 0
`define DIL_CFG_NOST_H 1
`define DIL_CFG_NOCH_L 2
`define DIL_CFG_NOCH_H 3
`define DIL_CFG_RESET 4'h0
// ----------------------------------------
// descriptor layout and encodings
// ----------------------------------------
`define DIL_D_FINAL 4
`define DIL_D_TC_LO 8
`define DIL_D_RO 11
`define DIL_D_NS 12
`define DIL_D_NOTIFY 26
`define DIL_D_ST_LO 27
`define DIL_D_KIND_LO 29
`define DIL_KIND_IMM 3'h2
`define DIL_ST_DONE 2'h1
`define DIL_ST_ERR 2'h3
`define DIL_LEN_MAX 4'h8
`define DIL_LEN_HI 4'h5
`define DIL_DESC_DW 4'h8
`define DIL_PAGE 13'h1000
`define DIL_BE_STATUS 4'h8
`endif

/* File: dil_pkg.sv */
// types shared by the immediate dma channel
package dil_pkg;
   // ----------------------------------------
   // request toward the express port
   // ----------------------------------------
   typedef struct packed {
      logic is_write;
      logic addr64;
      logic [63:2] addr;
      logic [3:0] len_dw;
      logic [3:0] first_be;
      logic [3:0] last_be;
      logic [2:0] tc;
      logic ro;
      logic ns;
      logic [95:0] data;
   } dil_tlp_type;

   // ----------------------------------------
   // channel sequencer states
   // ----------------------------------------
   typedef enum logic [6:0] {
      S_IDLE = 7'b0000001,
      S_FETCH = 7'b0000010,
      S_LOAD = 7'b0000100,
      S_CHECK = 7'b0001000,
      S_WRITE = 7'b0010000,
      S_WBACK = 7'b0100000,
      S_NEXT = 7'b1000000
   } dil_state_type;
endpackage

/* File: dil_chk_monitor.sv */
// port-level assertion checker for the immediate dma channel
`timescale 1ns/1ps
module dil_chk_monitor (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic RD,
   input wire logic [31:0] RDATA,
   input dil_pkg::dil_tlp_type REQ,
   input wire logic REQ_VALID,
   input wire logic REQ_READY
);
   import dil_pkg::*;
   default clocking @(posedge CLK);
   endclocking
   default disable iff (RESET);
   logic wr_req;
   logic [10:0] end_dw;
   // write request flag and last dword index within the page
   assign wr_req = REQ_VALID && REQ.is_write;
   assign end_dw = {1'b0, REQ.addr[11:2]} + {7'h00, REQ.len_dw} - 11'h001;

   property p_rdata_idle;
      !$past(RD) |-> RDATA == 32'h0;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
   property p_hold;
      REQ_VALID && !REQ_READY |=> REQ_VALID && $stable(REQ);
   endproperty
   a_hold: assert property (p_hold) else $error("request dropped or changed");
   property p_gap;
      REQ_VALID && REQ_READY |=> !REQ_VALID;
   endproperty
   a_gap: assert property (p_gap) else $error("request not lowered after accept");
   property p_fetch;
      REQ_VALID && !REQ.is_write |-> REQ.len_dw == 4'h8;
   endproperty
   a_fetch: assert property (p_fetch) else $error("descriptor read not eight dwords");
   property p_cpl;
      REQ_VALID && REQ_READY && !REQ.is_write |=> !REQ_VALID [*8];
   endproperty
   a_cpl: assert property (p_cpl) else $error("request during descriptor load");
   property p_page;
      wr_req |-> !end_dw[10];
   endproperty
   a_page: assert property (p_page) else $error("write crosses a 4 KB page");
   property p_hdr;
      REQ_VALID |-> REQ.addr64 == (REQ.addr[63:32] != 32'h0);
   endproperty
   a_hdr: assert property (p_hdr) else $error("header width wrong for address");
   property p_len;
      wr_req |-> REQ.len_dw inside {4'h1, 4'h2, 4'h3};
   endproperty
   a_len: assert property (p_len) else $error("write longer than eight bytes");
   property p_be1;
      wr_req && REQ.len_dw == 4'h1 |-> REQ.last_be == 4'h0 && REQ.first_be != 4'h0;
   endproperty
   a_be1: assert property (p_be1) else $error("single dword enables wrong");
   property p_contig;
      wr_req && REQ.len_dw != 4'h1 |-> REQ.first_be[3] && REQ.last_be[0];
   endproperty
   a_contig: assert property (p_contig) else $error("enables not contiguous");
   // main traffic shapes
   c_wide: cover property (wr_req && REQ_READY && REQ.addr64);
   c_three: cover property (wr_req && REQ_READY && REQ.len_dw == 4'h3);
   c_stall: cover property (REQ_VALID && !REQ_READY [*3]);
endmodule
bind dil_immediate_dma dil_chk_monitor u_mon (.CLK(CLK), .RESET(RESET), .RD(RD),
   .RDATA(RDATA), .REQ(REQ), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY));

/* File: dil_mem_model.sv */
// memory partner answering descriptor reads and logging posted writes
`timescale 1ns/1ps
module dil_mem_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic slow,
   input dil_pkg::dil_tlp_type req,
   input wire logic req_valid,
   output logic req_ready,
   output logic cpl_valid,
   output logic [31:0] cpl_data
);
   import dil_pkg::*;
   logic [31:0] mem [logic [61:0]];
   dil_tlp_type wlog [$];
   int wait_n;
   int cpl_n;
   logic [61:0] cpl_a;
   // dword at a byte address, filler where never written
   function automatic logic [31:0] peek(input logic [63:0] a);
      return mem.exists(a[63:2]) ? mem[a[63:2]] : 32'hDEAD_BEEF;
   endfunction
   // posted write stored under its enables, no completion
   task automatic store(input dil_tlp_type t);
      logic [31:0] w;
      logic [3:0] be;
      for (int i = 0; i < int'(t.len_dw); i++) begin
         w = peek({t.addr + 62'(i), 2'b00});
         be = (i == 0) ? t.first_be : ((i == int'(t.len_dw) - 1) ? t.last_be : 4'hF);
         for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
               w[8*b +: 8] = t.data[32*i + 8*b +: 8];
            end
         end
         mem[t.addr + 62'(i)] = w;
      end
      wlog.push_back(t);
   endtask
   // accept after an optional stall, then stream eight completion dwords for a read
   always @(posedge clk) begin
      if (rst) begin
         req_ready <= 1'b0;
         cpl_valid <= 1'b0;
         cpl_data <= 32'h0;
         wait_n = 0;
         cpl_n = 0;
      end else begin
         cpl_valid <= (cpl_n > 0);
         if (cpl_n > 0) begin
            cpl_data <= peek({cpl_a, 2'b00});
            cpl_a = cpl_a + 62'h1;
            cpl_n--;
         end else begin
            cpl_data <= ~cpl_data;
         end
         if (req_valid && req_ready) begin
            req_ready <= 1'b0;
            if (req.is_write) begin
               store(req);
            end else begin
               cpl_n = 8;
               cpl_a = req.addr;
            end
         end else if (req_valid && wait_n < (slow ? 4 : 0)) begin
            wait_n++;
         end else if (req_valid) begin
            req_ready <= 1'b1;
            wait_n = 0;
         end
      end
   end
endmodule

/* File: dil_immediate_dma_tb_top.sv */
// self-checking bench for the immediate dma channel
`timescale 1ns/1ps
`include "dil_params.svh"
module dil_immediate_dma_tb_top;
   import dil_pkg::*;
   logic clk;
   logic rst;
   logic wr;
   logic rd;
   logic slow;
   logic [7:0] addr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic [31:0] cpl_data;
   logic rdy;
   logic cpl_v;
   logic req_v;
   dil_tlp_type req;
   int bad_count = 0;
   int num_checks = 0;
   int n0;
   // 100 MHz clock
   always #5 clk = ~clk;
   dil_immediate_dma DUT (.CLK(clk), .RESET(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .REQ(req), .REQ_VALID(req_v), .REQ_READY(rdy),
      .CPL_VALID(cpl_v), .CPL_DATA(cpl_data));
   dil_mem_model MEM (.clk(clk), .rst(rst), .slow(slow), .req(req), .req_valid(req_v),
      .req_ready(rdy), .cpl_valid(cpl_v), .cpl_data(cpl_data));
   // comparison and verdict
   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH at %0t got %0h expected %0h", $time, g, e);
      end
   endtask
   task automatic print_verdict();
      if (bad_count == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // register bus cycles
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, e);
   endtask
   // poll the halted flag under a bound
   task automatic wait_halt();
      for (int i = 0; i < 300; i++) begin
         @(posedge clk);
         addr <= `DIL_OFS_STS;
         rd <= 1'b1;
         @(posedge clk);
         rd <= 1'b0;
         #1;
         // the status write may still wait at a stalling port after halt
         if (rdata[`DIL_STS_HALT] === 1'b1 && req_v === 1'b0) return;
      end
      bad_count++;
      print_verdict();
   endtask
   // descriptor building in partner memory
   function automatic logic [31:0] hdr(input logic nt, input logic [2:0] tc, input logic ro,
      input logic ns, input logic fin);
      return {`DIL_KIND_IMM, 2'h0, nt, 13'h0000, ns, ro, tc, 3'h0, fin, 4'h0};
   endfunction
   task automatic put(input logic [63:0] b, input logic [31:0] w0, input logic [3:0] n,
      input logic [31:0] dl, input logic [31:0] dh, input logic [63:0] dst,
      input logic [63:0] nx);
      logic [31:0] w [8];
      w = '{w0, {28'h0, n}, dl, dh, dst[31:0], dst[63:32], nx[31:0], nx[63:32]};
      for (int i = 0; i < 8; i++) begin
         MEM.mem[b[63:2] + 62'(i)] = w[i];
      end
   endtask
   task automatic fill(input logic [63:0] a, input int n);
      for (int i = 0; i < n; i++) begin
         MEM.mem[a[63:2] + 62'(i)] = 32'hFFFF_FFFF;
      end
   endtask
   // main sequence
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      slow = 1'b0;
      addr = 8'h00;
      wdata = 32'h0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         rd_chk(8'(4 * i), 32'h0);
      end
      put(64'h1000, hdr(1'b1, 3'h5, 1'b1, 1'b1, 1'b0), 4'h6, 32'h4433_2211, 32'h8877_6655,
         64'h2003, 64'h1100);
      put(64'h1100, hdr(1'b0, 3'h0, 1'b0, 1'b0, 1'b1), 4'h1, 32'hA5, 32'h0,
         64'h1_0000_0040, 64'h1200);
      fill(64'h2000, 3);
      fill(64'h1_0000_0040, 1);
      wr_reg(`DIL_OFS_DPL, 32'h1000);
      wait_halt();
      chk(MEM.wlog.size(), 4);
      chk(MEM.peek(64'h2000), 32'h11FF_FFFF);
      chk(MEM.peek(64'h2004), 32'h5544_3322);
      chk(MEM.peek(64'h2008), 32'hFFFF_FF66);
      chk({MEM.wlog[0].tc, MEM.wlog[0].ro, MEM.wlog[0].ns, MEM.wlog[0].addr64}, 6'h2E);
      chk(MEM.wlog[2].addr64, 1'b1);
      chk(MEM.peek(64'h1_0000_0040), 32'hFFFF_FFA5);
      chk(MEM.peek(64'h1000), hdr(1'b1, 3'h5, 1'b1, 1'b1, 1'b0) | 32'h0800_0000);
      chk(MEM.peek(64'h1100), hdr(1'b0, 3'h0, 1'b0, 1'b0, 1'b1) | 32'h0800_0000);
      rd_chk(`DIL_OFS_STS, 32'h3);
      rd_chk(`DIL_OFS_CTRL, 32'h0);
      rd_chk(`DIL_OFS_DPL, 32'h1100);
      // page split with a stalling port, started from the high pointer
      wr_reg(`DIL_OFS_STS, 32'hF);
      put(64'h1_0000_1200, hdr(1'b0, 3'h0, 1'b0, 1'b0, 1'b1), 4'h8, 32'h0403_0201,
         32'h0807_0605, 64'h2FFD, 64'h0);
      fill(64'h2FFC, 3);
      slow <= 1'b1;
      n0 = MEM.wlog.size();
      wr_reg(`DIL_OFS_CFG, 32'h1);
      wr_reg(`DIL_OFS_DPL, 32'h1200);
      rd_chk(`DIL_OFS_STS, 32'h0);
      wr_reg(`DIL_OFS_DPH, 32'h1);
      wait_halt();
      chk(MEM.wlog.size() - n0, 3);
      chk(MEM.peek(64'h2FFC), 32'h0302_01FF);
      chk(MEM.peek(64'h3000), 32'h0706_0504);
      chk(MEM.peek(64'h3004), 32'hFFFF_FF08);
      wr_reg(`DIL_OFS_CFG, 32'h0);
      slow <= 1'b0;
      // reserved length, blocked start, then run bit restart
      wr_reg(`DIL_OFS_STS, 32'hF);
      put(64'h1_0000_1300, hdr(1'b1, 3'h0, 1'b0, 1'b0, 1'b1), 4'h9, 32'h2211, 32'h0,
         64'h2100, 64'h0);
      fill(64'h2100, 1);
      n0 = MEM.wlog.size();
      wr_reg(`DIL_OFS_DPL, 32'h1300);
      wait_halt();
      chk(MEM.wlog.size() - n0, 1);
      chk(MEM.peek(64'h2100), 32'hFFFF_FFFF);
      chk(MEM.peek(64'h1_0000_1300), hdr(1'b1, 3'h0, 1'b0, 1'b0, 1'b1) | 32'h1800_0000);
      rd_chk(`DIL_OFS_STS, 32'h9);
      put(64'h1_0000_1300, hdr(1'b1, 3'h0, 1'b0, 1'b0, 1'b1), 4'h2, 32'h2211, 32'h0,
         64'h2100, 64'h0);
      wr_reg(`DIL_OFS_DPL, 32'h1300);
      rd_chk(`DIL_OFS_STS, 32'h9);
      wr_reg(`DIL_OFS_STS, 32'hF);
      wr_reg(`DIL_OFS_CTRL, 32'h1);
      wait_halt();
      chk(MEM.peek(64'h2100), 32'hFFFF_2211);
      // chaining from the next-list pointer
      wr_reg(`DIL_OFS_STS, 32'hF);
      put(64'h1100, hdr(1'b0, 3'h0, 1'b0, 1'b0, 1'b1), 4'h1, 32'hA5, 32'h0,
         64'h1_0000_0040, 64'h1200);
      wr_reg(`DIL_OFS_NDL, 32'h1100);
      wait_halt();
      rd_chk(`DIL_OFS_STS, 32'h5);
      rd_chk(`DIL_OFS_DPL, 32'h1100);
      rd_chk(`DIL_OFS_NDL, 32'h0);
      // blocked starts, then a chain at list end into a wrong-kind descriptor
      wr_reg(`DIL_OFS_STS, 32'hF);
      put(64'h1400, hdr(1'b1, 3'h0, 1'b0, 1'b0, 1'b1) ^ 32'h6000_0000, 4'h1, 32'h77, 32'h0,
         64'h2200, 64'h0);
      fill(64'h2200, 1);
      wr_reg(`DIL_OFS_CFG, 32'h6);
      wr_reg(`DIL_OFS_NDL, 32'h1400);
      wr_reg(`DIL_OFS_DPH, 32'h1);
      rd_chk(`DIL_OFS_STS, 32'h0);
      rd_chk(`DIL_OFS_NDL, 32'h1400);
      wr_reg(`DIL_OFS_DPH, 32'h0);
      wr_reg(`DIL_OFS_CFG, 32'h8);
      wr_reg(`DIL_OFS_DPL, 32'h1100);
      wait_halt();
      rd_chk(`DIL_OFS_STS, 32'hD);
      rd_chk(`DIL_OFS_DPL, 32'h1400);
      rd_chk(`DIL_OFS_NDL, 32'h0);
      rd_chk(`DIL_OFS_CTRL, 32'h0);
      chk(MEM.peek(64'h2200), 32'hFFFF_FFFF);
      chk(MEM.peek(64'h1400), 32'h3C00_0010);
      print_verdict();
   end
endmodule
